// ===== cycle_timer.sv
// Down counter shared by the core for its timed waits.
// Assumes load can be held for several cycles; done stays high until the next load.
`timescale 1ns/1ps

module cycle_timer (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    timer_if.timer    port
);
    logic [11:0] count_reg;
    logic        armed_reg;
    logic        done_reg;
    wire         at_zero;

    assign at_zero   = (count_reg == 12'h000);
    assign port.done = done_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            count_reg <= 12'h000;
            armed_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            if (port.load) begin
                count_reg <= port.value;
                armed_reg <= 1'b1;
            end else if (armed_reg && !at_zero) begin
                count_reg <= count_reg - 12'h001;
            end
            done_reg <= armed_reg && at_zero && !port.load;
        end
    end
endmodule : cycle_timer

// ===== line_sync.sv
// Three-stage synchroniser for the four line inputs.
// Assumes the raw inputs are asynchronous pins.
`timescale 1ns/1ps

module line_sync (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    sync_if.sync      port
);
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] clean_reg;
    logic [3:0] clean_next;
    wire  [3:0] agree;

    // A bit moves only once stages two and three agree
    assign agree      = ~(s2_reg ^ s3_reg);
    assign clean_next = (s2_reg & agree) | (clean_reg & ~agree);
    assign port.clean = clean_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s1_reg    <= 4'h0;
            s2_reg    <= 4'h0;
            s3_reg    <= 4'h0;
            clean_reg <= 4'h0;
        end else begin
            s1_reg    <= port.raw;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            clean_reg <= clean_next;
        end
    end
endmodule : line_sync

// ===== native_port_model.sv
// Native embedded port model: announce, then conclude on ack.
// Assumes the bench resolves the embedded wires with pull-downs.
`timescale 1ns/1ps

module native_port_model (
    input  wire logic clk_sys_i,
    input  wire logic connect_i,
    input  wire logic chirp_i,
    input  wire logic ack_i,
    output logic      drv_o,
    output logic      oe_o
);
    logic acked_reg;
    // raise announce, drop it on ack, release
    always @(posedge clk_sys_i) begin
        if (!connect_i) begin
            acked_reg <= 1'b0;
            oe_o      <= 1'b0;
            drv_o     <= 1'b0;
        end else if (!acked_reg) begin
            acked_reg <= ack_i;
            oe_o      <= 1'b1;
            drv_o     <= !ack_i;
        end else begin
            // chirp on eD- when told to go high speed
            oe_o  <= chirp_i;
            drv_o <= chirp_i;
        end
    end
endmodule : native_port_model

// ===== peripheral_repeater_connect_reset.sv
// Connect and early bus-reset sequencing of a peripheral-mode repeater.
// Assumes asynchronous line pins, a 10 MHz clock and a Wishbone master.
`timescale 1ns/1ps

module peripheral_repeater_connect_reset (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        usb_dp_i,
    input  wire logic        usb_dm_i,
    input  wire logic        ed_p_i,
    input  wire logic        ed_m_i,
    output logic             ed_p_o,
    output logic             ed_p_oe_o,
    output logic             ed_m_o,
    output logic             ed_m_oe_o,
    output logic             ed_pulldown_en_o,
    output logic             ed_se_rx_en_o,
    output logic             fs_xcvr_en_o,
    output logic             ls_xcvr_en_o,
    output logic             dp_pullup_en_o,
    output logic             dm_pullup_en_o,
    output logic             low_power_o,
    output logic             map_active_o,
    output logic             chirp_start_o,
    output logic             eor_start_o
);
    // ------------------------------------------------------------------
    // Line synchronisers and shared timer
    // ------------------------------------------------------------------
    sync_if  lines ();
    timer_if tmr ();

    line_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .port      (lines.sync)
    );

    cycle_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .port      (tmr.timer)
    );

    assign lines.raw = {ed_m_i, ed_p_i, usb_dm_i, usb_dp_i};

    wire dp_s  = lines.clean[repeater_pkg::LINE_DP];
    wire dm_s  = lines.clean[repeater_pkg::LINE_DM];
    wire edp_s = lines.clean[repeater_pkg::LINE_EDP];
    wire edm_s = lines.clean[repeater_pkg::LINE_EDM];

    repeater_pkg::state_e state_reg;
    repeater_pkg::state_e state_next;
    logic        speed_ls_reg;
    logic        speed_ls_next;
    logic        from_hs_reg;
    logic        from_hs_next;
    logic        pulled_seen_reg;
    logic        pulled_seen_next;
    logic        busrst_seen_reg;
    logic        busrst_seen_next;
    logic [3:0]  pulse_cnt_reg;
    logic [3:0]  pulse_cnt_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_ctrl   = bus_wr && (wb_adr_i == repeater_pkg::CTRL_OFS);
    wire wr_status = bus_wr && (wb_adr_i == repeater_pkg::STATUS_OFS);

    wire ctl_enable = ctrl_reg[repeater_pkg::CTRL_ENABLE_BIT];
    wire ctl_lx     = ctrl_reg[repeater_pkg::CTRL_LX_BIT];
    // Command bits act on the write and are never stored
    wire cmd_restart = wr_ctrl && wb_dat_i[repeater_pkg::CTRL_RESTART_BIT];
    wire cmd_hs_entry = wr_ctrl && wb_dat_i[repeater_pkg::CTRL_HS_ENTRY_BIT];
    wire busrst_clr  = wr_status && wb_dat_i[repeater_pkg::STAT_BUSRST_BIT];

    assign ctrl_next = wr_ctrl ?
        {28'h0000000, 1'b0, wb_dat_i[repeater_pkg::CTRL_LX_BIT], 1'b0,
         wb_dat_i[repeater_pkg::CTRL_ENABLE_BIT]} : ctrl_reg;

    wire [31:0] status_word = {22'h000000, edm_s, edp_s, dm_s, dp_s,
                               busrst_seen_reg, speed_ls_reg, 1'b0,
                               state_reg};
    // Unmapped addresses read as zero and still acknowledge
    wire [31:0] rd_data =
        (wb_adr_i == repeater_pkg::CTRL_OFS)   ? ctrl_reg :
        (wb_adr_i == repeater_pkg::STATUS_OFS) ? status_word : 32'h00000000;

    // ------------------------------------------------------------------
    // Line decode
    // ------------------------------------------------------------------
    wire se0_up      = !dp_s && !dm_s;
    wire up_line     = speed_ls_reg ? dm_s : dp_s;
    wire j_up        = speed_ls_reg ? (dm_s && !dp_s) : (dp_s && !dm_s);
    wire announce_in = speed_ls_reg ? edm_s : edp_s;
    wire in_se0      = (state_reg == repeater_pkg::ST_SUBSTATE_A);
    wire in_host_rst = (state_reg == repeater_pkg::ST_HOST_RESET);
    wire ack_high    = (state_reg == repeater_pkg::ST_ACK_HIGH);
    wire ack_drive   = ack_high || (state_reg == repeater_pkg::ST_ACK_LOW);
    wire connected   = !(state_reg == repeater_pkg::ST_ANNOUNCE);

    wire map_active = in_host_rst || (in_se0 && !from_hs_reg);
    wire map_drive  = map_active && pulled_seen_reg && se0_up;

    wire lx_drive = in_se0 && from_hs_reg && ctl_lx &&
                    (pulse_cnt_reg != 4'h0) && !tmr.done;

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        speed_ls_next = speed_ls_reg;
        from_hs_next  = from_hs_reg;
        case (state_reg)
            repeater_pkg::ST_ANNOUNCE: begin
                if (ctl_enable && edp_s) begin
                    state_next    = repeater_pkg::ST_ACK_CFG;
                    speed_ls_next = 1'b0;
                end else if (ctl_enable && edm_s) begin
                    state_next    = repeater_pkg::ST_ACK_CFG;
                    speed_ls_next = 1'b1;
                end
            end
            repeater_pkg::ST_ACK_CFG: begin
                if (up_line) begin
                    state_next = repeater_pkg::ST_ACK_HIGH;
                end
            end
            repeater_pkg::ST_ACK_HIGH: begin
                if (!announce_in) begin
                    state_next = repeater_pkg::ST_ACK_LOW;
                end
            end
            repeater_pkg::ST_ACK_LOW: begin
                if (tmr.done) begin
                    state_next = repeater_pkg::ST_HOST_RESET;
                end
            end
            repeater_pkg::ST_HOST_RESET: begin
                if (pulled_seen_reg && se0_up) begin
                    state_next   = repeater_pkg::ST_SUBSTATE_A;
                    from_hs_next = 1'b0;
                end
            end
            repeater_pkg::ST_SUBSTATE_A: begin
                if (!speed_ls_reg && edm_s) begin
                    state_next = repeater_pkg::ST_RESET_CHIRP;
                end else if (j_up) begin
                    state_next = repeater_pkg::ST_RESET_END;
                end
            end
            repeater_pkg::ST_RESET_CHIRP: begin
                state_next = repeater_pkg::ST_RESET_CHIRP;
            end
            repeater_pkg::ST_RESET_END: begin
                state_next = repeater_pkg::ST_RESET_END;
            end
            default: begin
                state_next = repeater_pkg::ST_ANNOUNCE;
            end
        endcase
        // High-speed entry needs an established connection
        if (cmd_hs_entry && (in_host_rst || in_se0 ||
            (state_reg == repeater_pkg::ST_RESET_CHIRP) ||
            (state_reg == repeater_pkg::ST_RESET_END))) begin
            state_next   = repeater_pkg::ST_SUBSTATE_A;
            from_hs_next = 1'b1;
        end
        if (cmd_restart) begin
            state_next = repeater_pkg::ST_ANNOUNCE;
        end
    end

    wire enter_ack_low = (state_next == repeater_pkg::ST_ACK_LOW) && ack_high;
    wire enter_se0 = (state_next == repeater_pkg::ST_SUBSTATE_A) &&
                     (!in_se0 || cmd_hs_entry);

    // SE0 length timer restarts off SE0
    assign tmr.load  = enter_ack_low || enter_se0 ||
                       (in_se0 && !from_hs_reg && !se0_up);
    assign tmr.value = enter_ack_low ? repeater_pkg::ACK_LOW_CYC :
                       (enter_se0 && from_hs_next) ?
                       repeater_pkg::HS_RESET_TO_FS_WINDOW_CYC :
                       repeater_pkg::BUS_SUBSTATE_A_CYC;

    assign pulled_seen_next = !connected ? 1'b0 :
                              (pulled_seen_reg || up_line);
    // Set wins over a software clear in the same cycle
    assign busrst_seen_next =
        (in_se0 && !from_hs_reg && se0_up && tmr.done) ||
        (busrst_seen_reg && !busrst_clr);
    assign pulse_cnt_next = (enter_se0 && from_hs_next) ?
                            repeater_pkg::LX_PULSE_CYC :
                            (pulse_cnt_reg != 4'h0) ?
                            pulse_cnt_reg - 4'h1 : 4'h0;

    // ------------------------------------------------------------------
    // Pin drive, all from registers
    // ------------------------------------------------------------------
    // acknowledge on opposite line
    wire edp_oe_next = (ack_drive && speed_ls_reg) ||
                       (map_drive && !speed_ls_reg) || lx_drive;
    wire edp_next    = (ack_high && speed_ls_reg) ||
                       (map_drive && !speed_ls_reg) || lx_drive;
    wire edm_oe_next = (ack_drive && !speed_ls_reg) ||
                       (map_drive && speed_ls_reg);
    wire edm_next    = (ack_high && !speed_ls_reg) ||
                       (map_drive && speed_ls_reg);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg        <= repeater_pkg::ST_ANNOUNCE;
            speed_ls_reg     <= 1'b0;
            from_hs_reg      <= 1'b0;
            pulled_seen_reg  <= 1'b0;
            busrst_seen_reg  <= 1'b0;
            pulse_cnt_reg    <= 4'h0;
            ctrl_reg         <= repeater_pkg::CTRL_RESET;
            wb_ack_o         <= 1'b0;
            wb_dat_o         <= 32'h00000000;
            ed_p_o           <= 1'b0;
            ed_p_oe_o        <= 1'b0;
            ed_m_o           <= 1'b0;
            ed_m_oe_o        <= 1'b0;
            ed_pulldown_en_o <= 1'b1;
            ed_se_rx_en_o    <= 1'b1;
            fs_xcvr_en_o     <= 1'b0;
            ls_xcvr_en_o     <= 1'b0;
            dp_pullup_en_o   <= 1'b0;
            dm_pullup_en_o   <= 1'b0;
            low_power_o      <= 1'b1;
            map_active_o     <= 1'b0;
            chirp_start_o    <= 1'b0;
            eor_start_o      <= 1'b0;
        end else begin
            state_reg        <= state_next;
            speed_ls_reg     <= speed_ls_next;
            from_hs_reg      <= from_hs_next;
            pulled_seen_reg  <= pulled_seen_next;
            busrst_seen_reg  <= busrst_seen_next;
            pulse_cnt_reg    <= pulse_cnt_next;
            ctrl_reg         <= ctrl_next;
            wb_ack_o         <= bus_req;
            wb_dat_o         <= bus_req ? rd_data : 32'h00000000;
            ed_p_o           <= edp_next;
            ed_p_oe_o        <= edp_oe_next;
            ed_m_o           <= edm_next;
            ed_m_oe_o        <= edm_oe_next;
            ed_pulldown_en_o <= 1'b1;
            ed_se_rx_en_o    <= 1'b1;
            fs_xcvr_en_o     <= connected && !speed_ls_reg;
            ls_xcvr_en_o     <= connected && speed_ls_reg;
            dp_pullup_en_o   <= connected && !speed_ls_reg;
            dm_pullup_en_o   <= connected && speed_ls_reg;
            low_power_o      <= !connected;
            map_active_o     <= map_active;
            chirp_start_o    <= in_se0 &&
                (state_next == repeater_pkg::ST_RESET_CHIRP);
            eor_start_o      <= in_se0 &&
                (state_next == repeater_pkg::ST_RESET_END);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_announce_upstream_off: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        (state_reg == repeater_pkg::ST_ANNOUNCE) |=>
        !fs_xcvr_en_o && !ls_xcvr_en_o && !dp_pullup_en_o && !dm_pullup_en_o)
        else $error("upstream enabled while announcing");

    a_pulldown_kept_on: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        $past(in_se0) |-> ed_pulldown_en_o && ed_se_rx_en_o)
        else $error("pull-down or receiver off in reset");

    a_idle_low_power: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        (state_reg == repeater_pkg::ST_ANNOUNCE) |=> low_power_o)
        else $error("not in low power while announcing");

    a_fs_class_select: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        (state_reg == repeater_pkg::ST_ANNOUNCE) && ctl_enable && edp_s &&
        !cmd_restart |=> (state_reg == repeater_pkg::ST_ACK_CFG) &&
        !speed_ls_reg ##1 fs_xcvr_en_o && dp_pullup_en_o)
        else $error("full-speed announce not configured");

    a_ack_after_pullup: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        (state_reg == repeater_pkg::ST_ACK_CFG) && up_line && !cmd_restart
        |=> ack_high ##1 (speed_ls_reg ? (ed_p_oe_o && ed_p_o)
                                       : (ed_m_oe_o && ed_m_o)))
        else $error("acknowledge not driven after pull-up");

    a_ack_held_low: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        (state_reg == repeater_pkg::ST_ACK_LOW) |=>
        (speed_ls_reg ? (ed_p_oe_o && !ed_p_o) : (ed_m_oe_o && !ed_m_o)))
        else $error("acknowledge line not held low");

    a_no_early_mapping: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !connected || ack_drive || (state_reg == repeater_pkg::ST_ACK_CFG)
        |=> !map_active_o)
        else $error("mapping before connection");

    a_se0_enters_reset: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        in_host_rst && pulled_seen_reg && se0_up && !cmd_restart &&
        !cmd_hs_entry |=> in_se0 && !from_hs_reg ##1 map_active_o)
        else $error("upstream SE0 did not start reset");

    a_hs_entry_no_pulse: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        in_se0 && from_hs_reg && !ctl_lx |=> !ed_p_oe_o && !ed_m_oe_o)
        else $error("eD line driven after high-speed reset entry");

    a_chirp_moves_on: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        in_se0 && !speed_ls_reg && edm_s && !cmd_restart && !cmd_hs_entry
        |=> (state_reg == repeater_pkg::ST_RESET_CHIRP) && chirp_start_o
        ##1 !chirp_start_o)
        else $error("device chirp not followed");

endmodule : peripheral_repeater_connect_reset

// ===== peripheral_repeater_connect_reset_bench.sv
// Bench: full then low speed connect, host reset and reset exit.
// Assumes the native port model and a pulled-up host side.
`timescale 1ns/1ps

module peripheral_repeater_connect_reset_bench;
    logic        clk_sys_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [3:0]  wb_adr_i  = 4'h0;
    logic [3:0]  wb_sel_i  = 4'hF;
    logic [31:0] wb_dat_i  = 32'h0;
    logic        connect   = 1'b0;
    logic        ls        = 1'b0;
    logic        se0       = 1'b0;
    logic        chirp     = 1'b0;
    logic [31:0] q, wb_dat_o;
    logic        wb_ack_o, ed_p_o, ed_p_oe_o, ed_m_o, ed_m_oe_o, drv, oe;
    logic        ed_pulldown_en_o, ed_se_rx_en_o, fs_xcvr_en_o, ls_xcvr_en_o;
    logic        dp_pullup_en_o, dm_pullup_en_o, low_power_o, map_active_o;
    logic        chirp_start_o, eor_start_o;
    int          err_total = 0;
    int          num_checks = 0;
    int          n;
    // released lines settle at the pull-down level
    wire ed_p_i = ed_p_oe_o ? ed_p_o : (oe & !ls & !chirp) ? drv : 1'b0;
    wire ed_m_i = ed_m_oe_o ? ed_m_o : (oe & (ls | chirp)) ? drv : 1'b0;
    wire usb_dp_i = dp_pullup_en_o & !se0;
    wire usb_dm_i = dm_pullup_en_o & !se0;

    always #50 clk_sys_i = ~clk_sys_i;

    peripheral_repeater_connect_reset i_dut (.clk_sys_i, .srst_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .usb_dp_i, .usb_dm_i, .ed_p_i, .ed_m_i, .ed_p_o,
        .ed_p_oe_o, .ed_m_o, .ed_m_oe_o, .ed_pulldown_en_o, .ed_se_rx_en_o,
        .fs_xcvr_en_o, .ls_xcvr_en_o, .dp_pullup_en_o, .dm_pullup_en_o,
        .low_power_o, .map_active_o, .chirp_start_o, .eor_start_o);
    native_port_model i_far (.clk_sys_i, .connect_i(connect), .chirp_i(chirp),
        .ack_i(ls ? ed_p_i : ed_m_i), .drv_o(drv), .oe_o(oe));

    task end_sim;
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask : chk

    // A used-up wait ends the run at once
    task lim;
        chk(n < 60, 1);
        if (n >= 60) end_sim;
    endtask : lim

    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 60);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        lim;
    endtask : wb

    initial begin
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys_i);
            srst_i  <= 1'b1;
            connect <= 1'b0;
            se0     <= 1'b0;
            ls      <= s[0];
            repeat (8) @(posedge clk_sys_i);
            srst_i <= 1'b0;
            @(negedge clk_sys_i);
            chk(low_power_o, 1);
            chk({ed_pulldown_en_o, ed_se_rx_en_o, fs_xcvr_en_o,
                 ls_xcvr_en_o}, 12);
            wb(1'b0, 4'h0, 32'h0);
            chk(q, 32'h00000001);
            wb(1'b1, 4'h8, 32'hFFFFFFFF);
            wb(1'b0, 4'h8, 32'h0);
            chk(q, 32'h0);
            connect <= 1'b1;
            for (n = 0; n < 60 && (s ? ed_p_i : ed_m_i) !== 1'b1; n++)
                @(negedge clk_sys_i);
            lim;
            chk({fs_xcvr_en_o, dp_pullup_en_o, ls_xcvr_en_o,
                 dm_pullup_en_o}, s ? 3 : 12);
            chk(map_active_o, 0);
            repeat (9) @(negedge clk_sys_i);
            chk(s ? {ed_p_oe_o, ed_p_o} : {ed_m_oe_o, ed_m_o}, 2);
            for (n = 0; n < 60 && map_active_o !== 1'b1; n++)
                @(negedge clk_sys_i);
            lim;
            chk(s ? ed_m_i : ed_p_i, 0);
            @(posedge clk_sys_i);
            se0 <= 1'b1;
            repeat (40) @(negedge clk_sys_i);
            chk(s ? ed_m_i : ed_p_i, 1);
            chk({ed_pulldown_en_o, ed_se_rx_en_o}, 3);
            wb(1'b0, 4'h4, 32'h0);
            chk({q[5:4], q[2:0]}, {1'b1, s[0], 3'h5});
            se0 <= 1'b0;
            for (n = 0; n < 60 && eor_start_o !== 1'b1; n++)
                @(negedge clk_sys_i);
            lim;
            @(posedge clk_sys_i);
            se0 <= 1'b1;
            repeat (5) @(posedge clk_sys_i);
            wb(1'b1, 4'h0, s ? 32'h7 : 32'h3);
            @(negedge clk_sys_i);
            chk({ed_p_oe_o, ed_p_o}, s ? 3 : 0);
            repeat (2) @(negedge clk_sys_i);
            chk({ed_p_oe_o, ed_m_oe_o}, 0);
            if (s == 0) begin
                @(posedge clk_sys_i);
                chirp <= 1'b1;
                for (n = 0; n < 60 && chirp_start_o !== 1'b1; n++)
                    @(negedge clk_sys_i);
                lim;
                @(posedge clk_sys_i);
                chirp <= 1'b0;
            end
            wb(1'b0, 4'h4, 32'h0);
            chk(q[2:0], s ? 5 : 6);
            repeat (4) @(posedge clk_sys_i);
            wb(1'b1, 4'h0, 32'h9);
            wb(1'b0, 4'h4, 32'h0);
            chk({q[2:0], fs_xcvr_en_o, ls_xcvr_en_o, low_power_o}, 1);
        end
        end_sim;
    end
endmodule : peripheral_repeater_connect_reset_bench

// ===== repeater_if.sv
// Bundles between the repeater core and its helper modules.
// Assumes all members except sync_if raw are on the system clock.
`timescale 1ns/1ps

interface sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport owner (output raw, input clean);
    modport sync  (input raw, output clean);
endinterface : sync_if

interface timer_if;
    logic        load;
    logic [11:0] value;
    logic        done;
    modport owner (output load, output value, input done);
    modport timer (input load, input value, output done);
endinterface : timer_if

// ===== repeater_pkg.sv
// Shared constants for the peripheral repeater connect and reset logic.
// Assumes a single 10 MHz system clock and a classic Wishbone slave port.
package repeater_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;

    // Least time the acknowledge line is held low before host reset
    localparam int ACK_LOW_NS = 1000;
    localparam logic [11:0] ACK_LOW_CYC =
        12'((ACK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Least SE0 length taken as a bus reset rather than packet SE0
    localparam int BUS_SUBSTATE_A_NS = 2500;
    localparam logic [11:0] BUS_SUBSTATE_A_CYC =
        12'((BUS_SUBSTATE_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Longest time to the full-speed fallback after a high-speed reset
    localparam int HS_RESET_TO_FS_WINDOW_NS = 3000;
    localparam logic [11:0] HS_RESET_TO_FS_WINDOW_CYC =
        12'(HS_RESET_TO_FS_WINDOW_NS / CLK_PERIOD_NS);

    // Least width of the low-power entry pulse on eD+
    localparam int LX_PULSE_NS = 200;
    localparam logic [3:0] LX_PULSE_CYC =
        4'((LX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFS       = 4'h0;
    localparam logic [3:0]  STATUS_OFS     = 4'h4;
    localparam logic [31:0] CTRL_RESET     = 32'h00000001;

    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_HS_ENTRY_BIT = 1;
    localparam int CTRL_LX_BIT       = 2;
    localparam int CTRL_RESTART_BIT  = 3;

    localparam int STAT_STATE_LSB    = 0;
    localparam int STAT_SPEED_LS_BIT = 4;
    localparam int STAT_BUSRST_BIT   = 5;
    localparam int STAT_DP_BIT       = 6;
    localparam int STAT_DM_BIT       = 7;
    localparam int STAT_EDP_BIT      = 8;
    localparam int STAT_EDM_BIT      = 9;

    // Synchronised line bit positions
    localparam int LINE_DP  = 0;
    localparam int LINE_DM  = 1;
    localparam int LINE_EDP = 2;
    localparam int LINE_EDM = 3;

    typedef enum logic [2:0] {
        ST_ANNOUNCE,
        ST_ACK_CFG,
        ST_ACK_HIGH,
        ST_ACK_LOW,
        ST_HOST_RESET,
        ST_SUBSTATE_A,
        ST_RESET_CHIRP,
        ST_RESET_END
    } state_e;

endpackage : repeater_pkg
